//--- core/timer_count_control.sv
// Purpose: counter control of a general timer, Avalon-MM slave
// Assumes: clk 10 MHz; trigIn, extClkIn, encDirIn are pins
// Notes:
// Notes on behaviour
// - Mode field: 00 edge by direction, 01 flags on down, 10 mode two
// - Mode two sets output compare flag only while counting up
// - Mode 11 alternates and flags compares both ways
// - Direction bit 4: 1 counts down, 0 counts up
// - Direction bit ignored in centre or encoder modes
// - Single pulse bit 3 clears counter enable at next update
// - Restrict bit 2 set: only over/underflow raises update request
// - Restrict clear: wrap, force update or slave raise request
// - Inhibit bit 1: no update, buffered values kept
// - Force update or slave reset still reinitialise counter, prescaler
// - Allowed updates from all sources reload buffered registers
// - Enable bit 0 starts or halts counting, resets to zero
// - Trigger slave mode sets counter enable in hardware
module timer_count_control
	import timer_ctl_pkg::*;
#(
	parameter int W = 16
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic trigIn,
	input wire logic extClkIn,
	input wire logic encDirIn,
	output logic updateIrq,
	output logic updateDma,
	output logic compareMatch
);
	// ----------------------------------------
	// Reset and pin synchronisers
	// ----------------------------------------
	logic [1:0] rstPipe;
	logic resetN;
	logic [2:0] trigSync, extSync, encSync;
	logic trigLvl, extLvl, encLvl, trigOld, extOld;
	logic trigRise, extRise;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rstPipe <= 2'h0;
		else
			rstPipe <= {rstPipe[0], 1'b1};
	end
	assign resetN = rstPipe[1];

	always_ff @(posedge clk or negedge resetN)
	begin
		if (!resetN)
		begin
			trigSync <= 3'h0;
			extSync <= 3'h0;
			encSync <= 3'h0;
		end
		else
		begin
			trigSync <= {trigSync[1:0], trigIn};
			extSync <= {extSync[1:0], extClkIn};
			encSync <= {encSync[1:0], encDirIn};
		end
	end

	// A change counts once stages two and three agree
	always_ff @(posedge clk or negedge resetN)
	begin
		if (!resetN)
		begin
			trigLvl <= 1'b0;
			extLvl <= 1'b0;
			encLvl <= 1'b0;
			trigOld <= 1'b0;
			extOld <= 1'b0;
		end
		else
		begin
			if (trigSync[1] == trigSync[2])
				trigLvl <= trigSync[2];
			if (extSync[1] == extSync[2])
				extLvl <= extSync[2];
			if (encSync[1] == encSync[2])
				encLvl <= encSync[2];
			trigOld <= trigLvl;
			extOld <= extLvl;
		end
	end
	assign trigRise = trigLvl && !trigOld;
	assign extRise = extLvl && !extOld;

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	logic [15:0] ctrl1, slaveMode, chMode, ie;
	logic [15:0] prescPre, reloadPre, cmpPre;
	logic [W-1:0] cnt, reloadSh, cmpSh;
	logic updFlag, cmpFlag, countDown;
	logic wrAcc;
	logic [15:0] wdata;

	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] be);
		merge = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
	endfunction

	function automatic logic hit(input logic [7:0] off);
		hit = wrAcc && (avs_address == off);
	endfunction

	// One wait cycle: request seen, then acknowledged
	always_ff @(posedge clk or negedge resetN)
	begin
		if (!resetN)
			avs_waitrequest <= 1'b1;
		else if (avs_waitrequest && (avs_read || avs_write))
			avs_waitrequest <= 1'b0;
		else
			avs_waitrequest <= 1'b1;
	end
	assign wrAcc = avs_write && !avs_waitrequest;
	assign wdata = avs_writedata[15:0];

	always_ff @(posedge clk or negedge resetN)
	begin
		if (!resetN)
			avs_readdata <= 32'h00000000;
		else if (avs_read && avs_waitrequest)
			case (avs_address)
				OFF_CTRL1: avs_readdata <= {16'h0000, ctrl1};
				OFF_STATUS: avs_readdata <= {29'h0, countDown, cmpFlag, updFlag};
				OFF_IE: avs_readdata <= {16'h0000, ie};
				OFF_SLAVE: avs_readdata <= {16'h0000, slaveMode};
				OFF_COUNT: avs_readdata <= {16'h0000, 16'(cnt)};
				OFF_PRESC: avs_readdata <= {16'h0000, prescPre};
				OFF_RELOAD: avs_readdata <= {16'h0000, reloadPre};
				OFF_CMP: avs_readdata <= {16'h0000, cmpPre};
				OFF_CHMODE: avs_readdata <= {16'h0000, chMode};
				default: avs_readdata <= 32'h00000000;
			endcase
	end

	always_ff @(posedge clk or negedge resetN)
	begin
		if (!resetN)
		begin
			ie <= 16'h0000;
			slaveMode <= 16'h0000;
			chMode <= 16'h0000;
			prescPre <= PRESC_RST;
			reloadPre <= RELOAD_RST;
			cmpPre <= CMP_RST;
		end
		else
		begin
			if (hit(OFF_IE))
				ie <= merge(ie, avs_writedata, avs_byteenable) & 16'h0003;
			if (hit(OFF_SLAVE))
				slaveMode <= merge(slaveMode, avs_writedata,
					avs_byteenable) & 16'h0007;
			if (hit(OFF_CHMODE))
				chMode <= merge(chMode, avs_writedata, avs_byteenable) & 16'h0003;
			if (hit(OFF_PRESC))
				prescPre <= merge(prescPre, avs_writedata, avs_byteenable);
			if (hit(OFF_RELOAD))
				reloadPre <= merge(reloadPre, avs_writedata, avs_byteenable);
			if (hit(OFF_CMP))
				cmpPre <= merge(cmpPre, avs_writedata, avs_byteenable);
		end
	end

	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	logic countOn, inhibit, srcRestrict, singlePulse;
	logic dirBit, centerMode, encMode;
	logic [1:0] alignSel;
	logic [2:0] sm;
	logic goingDown, run, step, tick, wrap;
	logic forceUpd, slaveRst, reinit, updEvent, updReq, cmpHit;

	assign countOn = ctrl1[ENABLE_BIT];
	assign inhibit = ctrl1[INHIBIT_BIT];
	assign srcRestrict = ctrl1[RESTRICT_BIT];
	assign singlePulse = ctrl1[PULSE_BIT];
	assign dirBit = ctrl1[DIR_BIT];
	assign alignSel = ctrl1[ALIGN_LSB+1:ALIGN_LSB];
	assign sm = slaveMode[2:0];
	assign centerMode = (alignSel != ALIGN_EDGE);
	assign encMode = (sm == SM_ENC);
	// Direction bit only matters in plain edge counting
	assign goingDown = centerMode ? countDown :
		(encMode ? encLvl : dirBit);
	// External sources count only after software sets the enable
	assign run = countOn && (sm != SM_GATED || trigLvl);
	assign step = run && ((sm == SM_EXT || encMode) ? extRise : 1'b1);
	assign wrap = tick && (goingDown ? (cnt == '0) : (cnt >= reloadSh));
	assign forceUpd = hit(OFF_EVENT) && avs_byteenable[0]
		&& wdata[FORCE_BIT];
	assign slaveRst = (sm == SM_RESET) && trigRise;
	assign reinit = forceUpd || slaveRst;
	assign updEvent = !inhibit && (wrap || reinit);
	assign updReq = updEvent && (!srcRestrict || wrap);

	// ----------------------------------------
	// Control register and enable
	// ----------------------------------------
	always_ff @(posedge clk or negedge resetN)
	begin
		if (!resetN)
			ctrl1 <= CTRL1_RST;
		else
		begin
			if (hit(OFF_CTRL1))
				ctrl1 <= merge(ctrl1, avs_writedata, avs_byteenable) & CTRL1_MASK;
			if (singlePulse && updEvent)
				ctrl1[ENABLE_BIT] <= 1'b0;
			if (sm == SM_TRIG && trigRise)
				ctrl1[ENABLE_BIT] <= 1'b1;
		end
	end

	timer_prescaler #(.W(W)) prescaler (
		.clk(clk),
		.resetN(resetN),
		.step(step),
		.restart(reinit),
		.load(updEvent),
		.preset(W'(prescPre)),
		.tick(tick)
	);

	// ----------------------------------------
	// Counter and shadows
	// ----------------------------------------
	// Shadows move only on an allowed update
	always_ff @(posedge clk or negedge resetN)
	begin
		if (!resetN)
		begin
			reloadSh <= W'(RELOAD_RST);
			cmpSh <= W'(CMP_RST);
		end
		else if (updEvent)
		begin
			reloadSh <= W'(reloadPre);
			cmpSh <= W'(cmpPre);
		end
	end

	always_ff @(posedge clk or negedge resetN)
	begin
		if (!resetN)
		begin
			cnt <= '0;
			countDown <= 1'b0;
		end
		else if (reinit)
		begin
			cnt <= (!centerMode && goingDown) ? reloadSh : '0;
			countDown <= !centerMode && goingDown;
		end
		else if (hit(OFF_COUNT))
			cnt <= W'(merge(16'(cnt), avs_writedata, avs_byteenable));
		else if (tick)
		begin
			if (!goingDown)
			begin
				if (cnt >= reloadSh)
				begin
					cnt <= centerMode ? cnt - W'(1) : '0;
					countDown <= centerMode;
				end
				else
					cnt <= cnt + W'(1);
			end
			else if (cnt == '0)
			begin
				cnt <= centerMode ? W'(1) : reloadSh;
				countDown <= 1'b0;
			end
			else
				cnt <= cnt - W'(1);
		end
		else if (!centerMode)
			countDown <= goingDown;
	end

	// ----------------------------------------
	// Flags and requests
	// ----------------------------------------
	// Compare flag qualified by centre mode and count phase
	always_comb
	begin
		cmpHit = 1'b0;
		if (tick && cnt == cmpSh && chMode[1:0] == CH_OUTPUT)
			case (alignSel)
				ALIGN_EDGE: cmpHit = 1'b1;
				ALIGN_DOWN_ONLY: cmpHit = goingDown;
				ALIGN_UP_ONLY: cmpHit = !goingDown;
				ALIGN_BOTH: cmpHit = 1'b1;
				default: cmpHit = 1'b0;
			endcase
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge clk or negedge resetN)
	begin
		if (!resetN)
		begin
			updFlag <= 1'b0;
			cmpFlag <= 1'b0;
		end
		else
		begin
			if (hit(OFF_STATUS) && avs_byteenable[0])
			begin
				if (wdata[ST_UPD])
					updFlag <= 1'b0;
				if (wdata[ST_CMP])
					cmpFlag <= 1'b0;
			end
			if (updReq)
				updFlag <= 1'b1;
			if (cmpHit)
				cmpFlag <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetN)
	begin
		if (!resetN)
		begin
			updateIrq <= 1'b0;
			updateDma <= 1'b0;
			compareMatch <= 1'b0;
		end
		else
		begin
			updateIrq <= updReq && ie[IE_UPD];
			updateDma <= updReq && ie[IE_DMA];
			compareMatch <= cmpHit;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetN);

	sequence s_single_update;
		singlePulse && updEvent && !(sm == SM_TRIG && trigRise);
	endsequence
	property p_single_stop;
		s_single_update |=> !countOn;
	endproperty
	a_single_stop: assert property (p_single_stop) else $error("enable kept");

	// Shadows must hold through an inhibited cycle
	property p_inhibit;
		inhibit |-> !updReq ##1 ($stable(reloadSh) && $stable(cmpSh));
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("update while inhibited");

	property p_restrict;
		(updReq && srcRestrict) |-> wrap;
	endproperty
	a_restrict: assert property (p_restrict) else $error("restricted source");

	property p_force;
		(forceUpd && !inhibit) |=> updFlag;
	endproperty
	a_force: assert property (p_force) else $error("force update lost");

	property p_reinit;
		(reinit && centerMode) |=> (cnt == '0);
	endproperty
	a_reinit: assert property (p_reinit) else $error("counter not reset");

	property p_down_step;
		(tick && !centerMode && !encMode && dirBit && cnt != '0 && !reinit
			&& !hit(OFF_COUNT)) |=> (cnt == $past(cnt) - W'(1));
	endproperty
	a_down_step: assert property (p_down_step) else $error("bad down step");

	property p_centre_turn;
		(tick && centerMode && !goingDown && cnt >= reloadSh && !reinit
			&& !hit(OFF_COUNT)) |=> countDown;
	endproperty
	a_centre_turn: assert property (p_centre_turn) else $error("no turn");

	property p_mode_two;
		(cmpHit && alignSel == ALIGN_UP_ONLY) |-> !goingDown ##1 compareMatch;
	endproperty
	a_mode_two: assert property (p_mode_two) else $error("mode two flag");

	property p_trigger;
		(sm == SM_TRIG && trigRise) |=> countOn;
	endproperty
	a_trigger: assert property (p_trigger) else $error("trigger no start");

	property p_wrap_up;
		(tick && !goingDown && !centerMode && cnt >= reloadSh && !reinit
			&& !hit(OFF_COUNT)) |=> (cnt == '0);
	endproperty
	a_wrap_up: assert property (p_wrap_up) else $error("no wrap");
endmodule

//--- core/timer_ctl_pkg.sv
// Purpose: shared constants of the timer counter control block
// Assumes: 32-bit Avalon-MM data, 16-bit timer registers
// Notes: offsets are byte addresses of aligned words
package timer_ctl_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_CTRL1 = 8'h00;
	localparam logic [7:0] OFF_CTRL2 = 8'h04;
	localparam logic [7:0] OFF_EVENT = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0C;
	localparam logic [7:0] OFF_IE = 8'h10;
	localparam logic [7:0] OFF_SLAVE = 8'h14;
	localparam logic [7:0] OFF_COUNT = 8'h18;
	localparam logic [7:0] OFF_PRESC = 8'h1C;
	localparam logic [7:0] OFF_RELOAD = 8'h20;
	localparam logic [7:0] OFF_CMP = 8'h24;
	localparam logic [7:0] OFF_CHMODE = 8'h28;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int ENABLE_BIT = 0;
	localparam int INHIBIT_BIT = 1;
	localparam int RESTRICT_BIT = 2;
	localparam int PULSE_BIT = 3;
	localparam int DIR_BIT = 4;
	localparam int ALIGN_LSB = 5;
	localparam int FORCE_BIT = 0;
	localparam int ST_UPD = 0;
	localparam int ST_CMP = 1;
	localparam int ST_DOWN = 2;
	localparam int IE_UPD = 0;
	localparam int IE_DMA = 1;
	localparam logic [15:0] CTRL1_MASK = 16'h007F;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] CTRL1_RST = 16'h0000;
	localparam logic [15:0] PRESC_RST = 16'h0000;
	localparam logic [15:0] RELOAD_RST = 16'hFFFF;
	localparam logic [15:0] CMP_RST = 16'h0000;
	// ----------------------------------------
	// Encodings
	// ----------------------------------------
	localparam logic [1:0] ALIGN_EDGE = 2'h0;
	localparam logic [1:0] ALIGN_DOWN_ONLY = 2'h1;
	localparam logic [1:0] ALIGN_UP_ONLY = 2'h2;
	localparam logic [1:0] ALIGN_BOTH = 2'h3;
	localparam logic [1:0] CH_OUTPUT = 2'h0;
	localparam logic [2:0] SM_OFF = 3'h0;
	localparam logic [2:0] SM_ENC = 3'h3;
	localparam logic [2:0] SM_RESET = 3'h4;
	localparam logic [2:0] SM_GATED = 3'h5;
	localparam logic [2:0] SM_TRIG = 3'h6;
	localparam logic [2:0] SM_EXT = 3'h7;
endpackage

//--- core/timer_prescaler.sv
// Purpose: prescaler dividing counter steps into ticks
// Assumes: step is a one-cycle enable
// Notes: divide value is buffered, taken at update
module timer_prescaler
	import timer_ctl_pkg::*;
#(
	parameter int W = 16
)
(
	input wire logic clk,
	input wire logic resetN,
	input wire logic step,
	input wire logic restart,
	input wire logic load,
	input wire logic [W-1:0] preset,
	output logic tick
);
	logic [W-1:0] divide;
	logic [W-1:0] count;

	assign tick = step && !restart && (count == divide);

	always_ff @(posedge clk or negedge resetN)
	begin
		if (!resetN)
			divide <= W'(PRESC_RST);
		else if (load)
			divide <= preset;
	end

	always_ff @(posedge clk or negedge resetN)
	begin
		if (!resetN)
			count <= '0;
		else if (restart || tick)
			count <= '0;
		else if (step)
			count <= count + W'(1);
	end
endmodule

//--- verification/timer_count_control_bench.sv
// Purpose: self-checking bench of the timer counter control block
// Assumes: design answers each bus request after one wait cycle
// Notes: expected values are constants written into the tests below
module timer_count_control_bench;
	import timer_ctl_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic trigIn = 1'b0;
	logic extClkIn = 1'b0;
	logic encDirIn = 1'b0;
	logic updateIrq;
	logic updateDma;
	logic compareMatch;
	int errors = 0;
	int n_compared = 0;
	int irqCount = 0;
	int dmaCount = 0;
	int cmpCount = 0;
	int seed;
	logic [31:0] rd;
	logic [15:0] v;
	int r;
	int rDma;
	int lo[$];
	int hi[$];
	always #50 clk = ~clk;
	timer_count_control u_timer_count_control (
		.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.trigIn(trigIn), .extClkIn(extClkIn), .encDirIn(encDirIn),
		.updateIrq(updateIrq), .updateDma(updateDma),
		.compareMatch(compareMatch)
	);
	// ----------------------------------------
	// Pulse counters
	// ----------------------------------------
	always @(posedge clk)
	begin
		irqCount <= irqCount + int'(updateIrq === 1'b1);
		dmaCount <= dmaCount + int'(updateDma === 1'b1);
		cmpCount <= cmpCount + int'(compareMatch === 1'b1);
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic complete_run();
		$display("Compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Request held until a rising edge sees waitrequest low
	// No cycle limit here: only the watchdog ends a stuck wait
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		do
			@(posedge clk);
		while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		bus(1'b1, a, {16'h0000, d});
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h00000000);
		check(rd, exp);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Pin pulses spaced wider than the three-stage filter
	task automatic pulses(input int n);
		repeat (n)
		begin
			extClkIn <= 1'b1;
			idle(4);
			extClkIn <= 1'b0;
			idle(4);
		end
		idle(6);
	endtask
	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	initial
	begin
		idle(20000);
		errors++;
		complete_run();
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		seed = $urandom(32'h767B77C3);
		idle(3);
		rst_n <= 1'b1;
		idle(3);
		// Reset values and unmapped place
		rdchk(OFF_CTRL1, 32'h00000000);
		rdchk(OFF_RELOAD, 32'h0000FFFF);
		rdchk(OFF_CTRL2, 32'h00000000);
		rdchk(8'h3C, 32'h00000000);
		$display("reset test done");
		// Field readback, every mode code, counter kept stopped
		for (int m = 0; m < 4; m++)
		begin
			v = 16'(($urandom() & 32'h1E) | (m << 5));
			wr(OFF_CTRL1, v | 16'hFF80);
			rdchk(OFF_CTRL1, {16'h0000, v});
		end
		$display("field test done");
		// Direction: edge down, edge up, centre ignores direction
		lo = '{16'h0010, 16'h0000, 16'h0030};
		hi = '{1, 0, 0};
		wr(OFF_RELOAD, 16'hFFFF);
		for (int i = 0; i < 3; i++)
		begin
			wr(OFF_CTRL1, 16'(lo[i]));
			wr(OFF_EVENT, 16'h0001);
			wr(OFF_CTRL1, 16'(lo[i] | 1));
			idle(20);
			wr(OFF_CTRL1, 16'(lo[i]));
			bus(1'b0, OFF_STATUS, 32'h00000000);
			check({31'h0, rd[2]}, 32'(hi[i]));
		end
		$display("direction test done");
		// Force update source against restrict and inhibit bits
		wr(OFF_IE, 16'h0003);
		for (int i = 0; i < 4; i++)
		begin
			wr(OFF_CTRL1, 16'(i << 1));
			wr(OFF_COUNT, 16'h0033);
			r = irqCount;
			rDma = dmaCount;
			wr(OFF_EVENT, 16'h0001);
			idle(10);
			check(32'(irqCount - r), 32'(i == 0));
			check(32'(dmaCount - rDma), 32'(i == 0));
			rdchk(OFF_COUNT, 32'h00000000);
		end
		$display("update source test done");
		// Single pulse with random reload, wrap to zero
		r = 4 + ($urandom() % 8);
		wr(OFF_CTRL1, 16'h0000);
		wr(OFF_RELOAD, 16'(r));
		wr(OFF_EVENT, 16'h0001);
		idle(5);
		r = irqCount;
		wr(OFF_CTRL1, 16'h000D);
		for (int n = 0; n < 100 && irqCount == r; n++)
			idle(1);
		idle(10);
		check(32'(irqCount - r), 32'h1);
		rdchk(OFF_CTRL1, 32'h0000000C);
		rdchk(OFF_COUNT, 32'h00000000);
		$display("single pulse test done");
		// Compare flags per mode: early window, then whole periods
		wr(OFF_RELOAD, 16'h0008);
		wr(OFF_CMP, 16'h0004);
		wr(OFF_CHMODE, 16'(CH_OUTPUT));
		lo = '{15, 8, 8, 17};
		hi = '{17, 10, 10, 19};
		for (int m = 0; m < 4; m++)
		begin
			wr(OFF_CTRL1, 16'(m << 5));
			wr(OFF_EVENT, 16'h0001);
			idle(3);
			r = cmpCount;
			wr(OFF_CTRL1, 16'((m << 5) | 1));
			idle(8);
			check(32'(cmpCount - r), 32'(m != 1));
			idle(134);
			wr(OFF_CTRL1, 16'(m << 5));
			check(32'(cmpCount - r >= lo[m] && cmpCount - r <= hi[m]),
				32'h1);
		end
		$display("compare mode test done");
		// Trigger slave mode sets enable by itself
		wr(OFF_CTRL1, 16'h0000);
		wr(OFF_SLAVE, 16'(SM_TRIG));
		idle(2);
		trigIn <= 1'b1;
		idle(20);
		rdchk(OFF_CTRL1, 32'h00000001);
		trigIn <= 1'b0;
		wr(OFF_SLAVE, 16'(SM_OFF));
		$display("trigger test done");
		// External clock needs enable; encoder pin overrides direction
		wr(OFF_CTRL1, 16'h0000);
		wr(OFF_SLAVE, 16'(SM_EXT));
		wr(OFF_EVENT, 16'h0001);
		pulses(3);
		rdchk(OFF_COUNT, 32'h00000000);
		wr(OFF_CTRL1, 16'h0001);
		pulses(5);
		rdchk(OFF_COUNT, 32'h00000005);
		encDirIn <= 1'b1;
		wr(OFF_SLAVE, 16'(SM_ENC));
		pulses(2);
		rdchk(OFF_COUNT, 32'h00000003);
		// Slave reset clears the counter even with updates inhibited
		wr(OFF_CTRL1, 16'h0002);
		wr(OFF_SLAVE, 16'(SM_RESET));
		r = irqCount;
		trigIn <= 1'b1;
		idle(8);
		trigIn <= 1'b0;
		rdchk(OFF_COUNT, 32'h00000000);
		check(32'(irqCount - r), 32'h0);
		$display("slave mode test done");
		complete_run();
	end
endmodule
